// ### core/pcar_pkg.sv
/*
  Constants for the configuration access router: I/O addresses, address
  register fields, reset values and the route and cycle-type encodings.
  Assumes a single host clock and the router that imports this package.
*/
package pcar_pkg;
  localparam logic [15:0] PCAR_ADDR_IO      = 16'h0cf8;
  localparam logic [15:0] PCAR_DATA_IO      = 16'h0cfc;
  localparam logic [31:0] PCAR_ADDR_RESET   = 32'h00000000;
  localparam logic [31:0] PCAR_DATA_RESET   = 32'h00000000;
  localparam logic [31:0] PCAR_ADDR_WMASK   = 32'h80fffffc;
  localparam logic [31:0] PCAR_ALL_ONES     = 32'hffffffff;
  localparam logic [3:0]  PCAR_BE_DWORD     = 4'hf;
  localparam int          PCAR_EN_BIT       = 31;
  localparam int          PCAR_BUS_LSB      = 16;
  localparam int          PCAR_DEV_LSB      = 11;
  localparam int          PCAR_FUNC_LSB     = 8;
  localparam int          PCAR_REG_LSB      = 2;
  localparam logic [4:0]  PCAR_DEV_INT_LAST = 5'h03;
  localparam int          PCAR_IDSEL_BASE   = 16;

  // Route targets of a forwarded cycle
  typedef enum logic [2:0] {
    PCAR_TGT_INTERNAL,
    PCAR_TGT_PRIMARY,
    PCAR_TGT_GRAPHICS,
    PCAR_TGT_SEC2,
    PCAR_TGT_SEC3,
    PCAR_TGT_NONE
  } pcar_tgt_type;

  // Kind of cycle placed on the chosen link
  typedef enum logic [1:0] {
    PCAR_CYC_IO,
    PCAR_CYC_CFG0,
    PCAR_CYC_CFG1
  } pcar_cyc_type;
endpackage

// ### core/pcar_decode.sv
/*
  Combinational routing decode of a configuration address. Assumes bridge
  bus numbers come from the bridge register files outside this block.
*/
module pcar_decode
  import pcar_pkg::*;
(
  input  wire logic [31:0]  i_addr,
  input  wire logic [3:0]   i_int_enable,
  input  wire logic [7:0]   i_sec_bus [1:3],
  input  wire logic [7:0]   i_sub_bus [1:3],
  output pcar_tgt_type      o_tgt,
  output pcar_cyc_type      o_cyc,
  output logic      [1:0]   o_int_func
);
  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] func;

  assign bus  = i_addr[PCAR_BUS_LSB +: 8];
  assign dev  = i_addr[PCAR_DEV_LSB +: 5];
  assign func = i_addr[PCAR_FUNC_LSB +: 3];

  always_comb
  begin
    o_tgt      = PCAR_TGT_PRIMARY;
    o_cyc      = PCAR_CYC_CFG1;
    o_int_func = dev[1:0];
    if (bus == 8'h00)
    begin
      o_cyc = PCAR_CYC_CFG0;
      if (dev <= PCAR_DEV_INT_LAST && i_int_enable[dev[1:0]])
      begin
        // Nonzero function to an internal device is dropped, not forwarded
        o_tgt = (func == 3'h0) ? PCAR_TGT_INTERNAL : PCAR_TGT_NONE;
      end
      else
      begin
        o_tgt = PCAR_TGT_PRIMARY;
      end
    end
    else if (bus == i_sec_bus[1])
    begin
      o_tgt = PCAR_TGT_GRAPHICS;
      o_cyc = PCAR_CYC_CFG0;
    end
    else if (bus > i_sec_bus[1] && bus <= i_sub_bus[1])
    begin
      o_tgt = PCAR_TGT_GRAPHICS;
      o_cyc = PCAR_CYC_CFG1;
    end
    else if (bus == i_sec_bus[2])
    begin
      o_tgt = PCAR_TGT_SEC2;
      o_cyc = PCAR_CYC_CFG0;
    end
    else if (bus > i_sec_bus[2] && bus <= i_sub_bus[2])
    begin
      o_tgt = PCAR_TGT_SEC2;
      o_cyc = PCAR_CYC_CFG1;
    end
    else if (bus == i_sec_bus[3])
    begin
      o_tgt = PCAR_TGT_SEC3;
      o_cyc = PCAR_CYC_CFG0;
    end
    else if (bus > i_sec_bus[3] && bus <= i_sub_bus[3])
    begin
      o_tgt = PCAR_TGT_SEC3;
      o_cyc = PCAR_CYC_CFG1;
    end
    else
    begin
      o_tgt = PCAR_TGT_PRIMARY;
      o_cyc = PCAR_CYC_CFG1;
    end
  end
endmodule

// ### core/pcar_router.sv
/*
  Host I/O configuration access router: address register, data window,
  and forwarding of each access not claimed or ignored locally to internal functions, the primary hub link,
  the graphics port or a secondary hub link. Assumes host I/O requests are
  single-cycle strobes synchronous to i_clk_sys, and each downstream target
  answers with a one-cycle done pulse carrying read data.
*/
module pcar_router
  import pcar_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  // Host I/O request
  input  wire logic         i_io_req,
  input  wire logic         i_io_write,
  input  wire logic [15:0]  i_io_addr,
  input  wire logic [3:0]   i_io_be,
  input  wire logic [31:0]  i_io_wdata,
  output logic              o_io_ready,
  output logic      [31:0]  o_io_rdata,
  // Bridge bus numbers, index 1 graphics, 2 and 3 secondary links
  input  wire logic [7:0]   i_sec_bus [1:3],
  input  wire logic [7:0]   i_sub_bus [1:3],
  input  wire logic [1:0]   i_int_func_enable,
  // Hub link line 11 for each secondary link, sampled at reset release
  input  wire logic [1:0]   i_hub_link_line_11,
  // Downstream cycle
  output logic              o_cyc_valid,
  output pcar_tgt_type      o_cyc_tgt,
  output pcar_cyc_type      o_cyc_kind,
  output logic              o_cyc_write,
  output logic      [31:0]  o_cyc_addr,
  output logic      [3:0]   o_cyc_be,
  output logic      [31:0]  o_cyc_wdata,
  output logic      [1:0]   o_cyc_int_func,
  input  wire logic         i_cyc_done,
  input  wire logic [31:0]  i_cyc_rdata,
  output logic      [1:0]   o_sec_populated
);
  typedef enum logic [1:0] {PCAR_ST_IDLE, PCAR_ST_WAIT, PCAR_ST_ANSWER} pcar_st_type;

  logic              rst_meta_q;
  logic              rst_sync_q;
  logic              strap_pending_q;
  logic      [1:0]   sec_pop_q;
  logic      [31:0]  cfg_address_q;
  logic      [31:0]  cfg_window_bits_q;
  pcar_st_type       st_q;
  logic              ans_q;
  logic      [31:0]  rdata_q;
  logic              cyc_valid_q;
  pcar_tgt_type      cyc_tgt_q;
  pcar_cyc_type      cyc_kind_q;
  logic              cyc_write_q;
  logic      [31:0]  cyc_addr_q;
  logic      [3:0]   cyc_be_q;
  logic      [31:0]  cyc_wdata_q;
  logic      [1:0]   cyc_int_func_q;
  pcar_tgt_type      dec_tgt;
  pcar_cyc_type      dec_cyc;
  logic      [1:0]   dec_func;
  logic      [3:0]   int_enable;
  logic              hit_addr;
  logic              hit_data;
  logic              dword;
  logic              cfg_enable;
  logic              take;

  // Devices 0 and 1 never disabled; 2 and 3 follow their enable and population
  assign int_enable = {i_int_func_enable[1] & sec_pop_q[1],
                       i_int_func_enable[0] & sec_pop_q[0], 2'b11};

  pcar_decode u_decode (
    .i_addr       (cfg_address_q),
    .i_int_enable (int_enable),
    .i_sec_bus    (i_sec_bus),
    .i_sub_bus    (i_sub_bus),
    .o_tgt        (dec_tgt),
    .o_cyc        (dec_cyc),
    .o_int_func   (dec_func)
  );

  assign hit_addr   = (i_io_addr == PCAR_ADDR_IO);
  assign hit_data   = (i_io_addr == PCAR_DATA_IO);
  assign dword      = (i_io_be == PCAR_BE_DWORD);
  assign cfg_enable = cfg_address_q[PCAR_EN_BIT];
  assign take       = i_io_req && (st_q == PCAR_ST_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // Reset release

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Strap caught on the first clock after release, never under reset
  always_ff @(posedge i_clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      strap_pending_q <= 1'b1;
      sec_pop_q       <= 2'b00;
    end
    else if (strap_pending_q)
    begin
      strap_pending_q <= 1'b0;
      sec_pop_q       <= i_hub_link_line_11;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address register

  always_ff @(posedge i_clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      cfg_address_q <= PCAR_ADDR_RESET;
    else if (take && i_io_write && hit_addr && dword)
      // Reserved bits stay zero whatever is written
      cfg_address_q <= i_io_wdata & PCAR_ADDR_WMASK;
  end

  //////////////////////////////////////////////////////////////////////////
  // Data window holds the last value written to it or returned by any forwarded read

  always_ff @(posedge i_clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      cfg_window_bits_q <= PCAR_DATA_RESET;
    else if (take && i_io_write && hit_data)
      cfg_window_bits_q <= i_io_wdata;
    else if (st_q == PCAR_ST_WAIT && i_cyc_done && !cyc_write_q)
      cfg_window_bits_q <= i_cyc_rdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // Request sequencing and downstream cycle

  always_ff @(posedge i_clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      st_q           <= PCAR_ST_IDLE;
      ans_q          <= 1'b0;
      rdata_q        <= 32'h00000000;
      cyc_valid_q    <= 1'b0;
      cyc_tgt_q      <= PCAR_TGT_PRIMARY;
      cyc_kind_q     <= PCAR_CYC_IO;
      cyc_write_q    <= 1'b0;
      cyc_addr_q     <= 32'h00000000;
      cyc_be_q       <= 4'h0;
      cyc_wdata_q    <= 32'h00000000;
      cyc_int_func_q <= 2'b00;
    end
    else
    begin
      ans_q       <= 1'b0;
      cyc_valid_q <= 1'b0;
      unique case (st_q)
        PCAR_ST_IDLE:
        begin
          if (take)
          begin
            cyc_write_q <= i_io_write;
            cyc_be_q    <= i_io_be;
            cyc_wdata_q <= i_io_wdata;
            if (hit_addr && dword)
            begin
              // Claimed locally, answered next cycle
              rdata_q <= cfg_address_q;
              ans_q   <= 1'b1;
              st_q    <= PCAR_ST_ANSWER;
            end
            else if (hit_data && cfg_enable)
            begin
              // Uses the address as already loaded by the host
              cyc_tgt_q      <= dec_tgt;
              cyc_kind_q     <= dec_cyc;
              cyc_int_func_q <= dec_func;
              cyc_addr_q     <= route_addr(cfg_address_q, dec_tgt, dec_cyc);
              if (dec_tgt == PCAR_TGT_NONE)
              begin
                // Ignored access: writes dropped, reads float high
                rdata_q <= PCAR_ALL_ONES;
                ans_q   <= 1'b1;
                st_q    <= PCAR_ST_ANSWER;
              end
              else
              begin
                cyc_valid_q <= 1'b1;
                st_q        <= PCAR_ST_WAIT;
              end
            end
            else
            begin
              // Partial access to the address port, disabled window, other I/O
              cyc_tgt_q   <= PCAR_TGT_PRIMARY;
              cyc_kind_q  <= PCAR_CYC_IO;
              cyc_addr_q  <= {16'h0000, i_io_addr};
              cyc_valid_q <= 1'b1;
              st_q        <= PCAR_ST_WAIT;
            end
          end
        end
        PCAR_ST_WAIT:
        begin
          if (i_cyc_done)
          begin
            rdata_q <= i_cyc_rdata;
            ans_q   <= 1'b1;
            st_q    <= PCAR_ST_ANSWER;
          end
        end
        PCAR_ST_ANSWER:
        begin
          st_q <= PCAR_ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address formatting for the chosen target

  function automatic logic [31:0] route_addr(input logic [31:0] a,
                                             input pcar_tgt_type t,
                                             input pcar_cyc_type c);
    logic [31:0] r;
    logic [4:0]  dv;
    r  = {24'h000000, a[PCAR_REG_LSB +: 6], 2'b00};
    dv = a[PCAR_DEV_LSB +: 5];
    r[PCAR_FUNC_LSB +: 3] = a[PCAR_FUNC_LSB +: 3];
    if (t == PCAR_TGT_GRAPHICS && c == PCAR_CYC_CFG0)
    begin
      // One select line per device; device 16 and above gets none
      if (!dv[4])
        r[PCAR_IDSEL_BASE + 32'(dv[3:0])] = 1'b1;
    end
    else
    begin
      r[PCAR_DEV_LSB +: 5] = dv;
      if (c == PCAR_CYC_CFG1)
        r[PCAR_BUS_LSB +: 8] = a[PCAR_BUS_LSB +: 8];
    end
    return r;
  endfunction

  assign o_io_ready      = ans_q;
  assign o_io_rdata      = rdata_q;
  assign o_cyc_valid     = cyc_valid_q;
  assign o_cyc_tgt       = cyc_tgt_q;
  assign o_cyc_kind      = cyc_kind_q;
  assign o_cyc_write     = cyc_write_q;
  assign o_cyc_addr      = cyc_addr_q;
  assign o_cyc_be        = cyc_be_q;
  assign o_cyc_wdata     = cyc_wdata_q;
  assign o_cyc_int_func  = cyc_int_func_q;
  assign o_sec_populated = sec_pop_q;
endmodule

// ### sim/pcar_router_asserts.sv
/* Checker for pcar_router, bound at the foot of this file.
   Assumes the host keeps at most one request outstanding. */
module pcar_router_asserts
  import pcar_pkg::*;
(
  input wire logic         i_clk_sys,
  input wire logic         i_nrst,
  input wire logic         i_io_req,
  input wire logic         i_io_write,
  input wire logic  [15:0] i_io_addr,
  input wire logic  [3:0]  i_io_be,
  input wire logic  [31:0] i_io_wdata,
  input wire logic         o_io_ready,
  input wire logic  [31:0] o_io_rdata,
  input wire logic         o_cyc_valid,
  input wire pcar_tgt_type o_cyc_tgt,
  input wire pcar_cyc_type o_cyc_kind,
  input wire logic  [31:0] o_cyc_addr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic        busy_q;
  logic [31:0] cfg_q;
  wire         take = i_io_req && !busy_q;
  wire         dw   = i_io_be == PCAR_BE_DWORD;
  wire         cfg  = o_cyc_valid && o_cyc_kind != PCAR_CYC_IO;
  //////////////////////////////////////////////////
  // Requests made while busy are dropped, so only idle ones count
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      busy_q <= 1'b0;
    else if (take || o_io_ready)
      busy_q <= take;
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      cfg_q <= PCAR_ADDR_RESET;
    else if (take && i_io_write && dw && i_io_addr == PCAR_ADDR_IO)
      cfg_q <= i_io_wdata & PCAR_ADDR_WMASK;
  end
  //////////////////////////////////////////////////
  sequence s_cf8;
    take && i_io_addr == PCAR_ADDR_IO;
  endsequence
  sequence s_cfc;
    take && i_io_addr == PCAR_DATA_IO;
  endsequence
  AST_CF8_WR: assert property (
    s_cf8 ##0 (i_io_write && dw) |=> o_io_ready && !o_cyc_valid) else $error("cf8 write");
  AST_CF8_RD: assert property (
    s_cf8 ##0 (!i_io_write && dw) |=> o_io_ready && o_io_rdata == cfg_q) else $error("cf8 read");
  AST_CF8_PART: assert property (
    s_cf8 ##0 !dw |=> o_cyc_valid && o_cyc_tgt == PCAR_TGT_PRIMARY && o_cyc_kind == PCAR_CYC_IO
    && o_cyc_addr == {16'h0, PCAR_ADDR_IO}) else $error("partial cf8 not forwarded");
  AST_CFC_OFF: assert property (
    s_cfc ##0 !cfg_q[31] |=> o_cyc_valid && o_cyc_kind == PCAR_CYC_IO
    && o_cyc_tgt == PCAR_TGT_PRIMARY) else $error("disabled window not io");
  AST_CFC_ON: assert property (
    s_cfc ##0 (cfg_q[31] && cfg_q[10:8] == 3'h0) |=> cfg ##1 !o_cyc_valid) else $error("no cfg");
  AST_IGNORE: assert property (
    s_cfc ##0 (cfg_q[31] && cfg_q[23:11] < 13'h2 && cfg_q[10:8] != 3'h0)
    |=> o_io_ready && !o_cyc_valid) else $error("internal func not ignored");
  AST_FIELDS: assert property (
    cfg |-> o_cyc_addr[10:2] == cfg_q[10:2]) else $error("func or reg field wrong");
  AST_IDSEL: assert property (
    cfg && o_cyc_tgt == PCAR_TGT_GRAPHICS && o_cyc_kind == PCAR_CYC_CFG0
    |-> o_cyc_addr[31:16] == (cfg_q[15] ? 16'h0 : 16'h1 << cfg_q[14:11])) else $error("idsel");
endmodule
bind pcar_router pcar_router_asserts i_chk (.i_clk_sys, .i_nrst, .i_io_req, .i_io_write,
  .i_io_addr, .i_io_be, .i_io_wdata, .o_io_ready, .o_io_rdata, .o_cyc_valid, .o_cyc_tgt,
  .o_cyc_kind, .o_cyc_addr);

// ### sim/pcar_target_model.sv
/* Downstream target model: answers each launched cycle after a set delay.
   Assumes the router launches one cycle at a time and holds its address. */
module pcar_target_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_cyc_valid,
  input  wire logic [31:0] i_cyc_addr,
  input  wire logic [3:0]  i_delay,
  output logic             o_done,
  output logic      [31:0] o_rdata
);
  logic       busy_q;
  logic [3:0] wait_q;
  // Data toggles outside the answer so a late capture is caught
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      busy_q  <= 1'b0;
      wait_q  <= 4'h0;
      o_done  <= 1'b0;
      o_rdata <= 32'h0;
    end
    else
    begin
      o_done  <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_cyc_valid)
      begin
        busy_q <= 1'b1;
        wait_q <= i_delay;
      end
      else if (busy_q && wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (busy_q)
      begin
        busy_q  <= 1'b0;
        o_done  <= 1'b1;
        o_rdata <= i_cyc_addr ^ 32'ha5a50000;
      end
    end
  end
endmodule

// ### sim/pci_config_access_router_tb.sv
/* Bench for pcar_router: host I/O tasks, target model, scenario checks.
   Assumes the checker is bound to the router from its own file. */
`define CK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module pci_config_access_router_tb
  import pcar_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk = 1'b0, nrst = 1'b0, req = 1'b0, wr = 1'b0;
  logic         ready, valid, cwr, done, seen;
  logic  [15:0] addr = 16'h0;
  logic  [3:0]  be = 4'h0, dly = 4'h0, cbe;
  logic  [31:0] wdata = 32'h0, rdata, caddr, cwdata, mrdata;
  logic  [1:0]  strap = 2'h3, int_en = 2'h1, ifunc, popd;
  logic  [7:0]  sec [1:3] = '{8'h10, 8'h20, 8'h30};
  logic  [7:0]  sub [1:3] = '{8'h1f, 8'h2f, 8'h3f};
  pcar_tgt_type tgt;
  pcar_cyc_type kind;
  int           fail_count = 0;
  int           n_tests = 0;
  always #2.5 clk = ~clk;
  pcar_router i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_io_req(req), .i_io_write(wr),
    .i_io_addr(addr), .i_io_be(be), .i_io_wdata(wdata), .o_io_ready(ready), .o_io_rdata(rdata),
    .i_sec_bus(sec), .i_sub_bus(sub), .i_int_func_enable(int_en), .i_hub_link_line_11(strap),
    .o_cyc_valid(valid), .o_cyc_tgt(tgt), .o_cyc_kind(kind), .o_cyc_write(cwr),
    .o_cyc_addr(caddr), .o_cyc_be(cbe), .o_cyc_wdata(cwdata), .o_cyc_int_func(ifunc),
    .i_cyc_done(done), .i_cyc_rdata(mrdata), .o_sec_populated(popd));
  pcar_target_model i_tgt (.i_clk_sys(clk), .i_nrst(nrst), .i_cyc_valid(valid),
    .i_cyc_addr(caddr), .i_delay(dly), .o_done(done), .o_rdata(mrdata));
  //////////////////////////////////////////////////
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    int k;
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = a;
    be = b;
    wdata = d;
    @(negedge clk);
    req = 1'b0;
    seen = 1'b0;
    for (k = 0; k < 40 && ready !== 1'b1; k++)
    begin
      if (valid === 1'b1)
        seen = 1'b1;
      @(negedge clk);
    end
    `CK(ready, 1'b1)
  endtask
  // Host loads the address, enable bit set, before each enabled window access
  task automatic sel(input logic [7:0] b, input logic [4:0] d, input logic [2:0] f);
    io(1'b1, PCAR_ADDR_IO, PCAR_BE_DWORD, {1'b1, 7'h0, b, d, f, 6'h2a, 2'h0});
  endtask
  task automatic do_reset(input logic [1:0] s);
    nrst = 1'b0;
    strap = s;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    `CK(popd, s)
  endtask
  //////////////////////////////////////////////////
  task automatic t_regs;
    io(1'b0, PCAR_ADDR_IO, PCAR_BE_DWORD, 32'h0);
    `CK(rdata, PCAR_ADDR_RESET)
    io(1'b0, PCAR_DATA_IO, PCAR_BE_DWORD, 32'h0);
    `CK({seen, tgt, kind}, {1'b1, PCAR_TGT_PRIMARY, PCAR_CYC_IO})
    `CK(rdata, 32'ha5a50cfc)
    io(1'b1, PCAR_ADDR_IO, PCAR_BE_DWORD, PCAR_ALL_ONES);
    `CK(seen, 1'b0)
    io(1'b1, PCAR_ADDR_IO, 4'h3, 32'h0);
    `CK({tgt, kind, caddr}, {PCAR_TGT_PRIMARY, PCAR_CYC_IO, 32'h00000cf8})
    `CK(cbe, 4'h3)
    io(1'b0, PCAR_ADDR_IO, PCAR_BE_DWORD, 32'h0);
    `CK(rdata, PCAR_ADDR_WMASK)
    $display("regs done");
  endtask
  task automatic t_bus0;
    for (int d = 0; d < 8; d++)
    begin
      sel(8'h0, d[4:0], 3'h0);
      io(1'b0, PCAR_DATA_IO, PCAR_BE_DWORD, 32'h0);
      `CK(tgt, d < 3 ? PCAR_TGT_INTERNAL : PCAR_TGT_PRIMARY)
      `CK({kind, caddr[15:0]}, {PCAR_CYC_CFG0, d[4:0], 11'h0a8})
      if (d < 3)
        `CK(ifunc, d[1:0])
      if (d == 1)
        `CK(rdata, 32'ha5a508a8)
    end
    sel(8'h0, 5'h1, 3'h2);
    io(1'b0, PCAR_DATA_IO, PCAR_BE_DWORD, 32'h0);
    `CK({seen, rdata}, {1'b0, PCAR_ALL_ONES})
    $display("bus0 done");
  endtask
  task automatic t_bridges;
    logic [7:0] bl [10] = '{8'h10, 8'h10, 8'h15, 8'h1f, 8'h20, 8'h2f, 8'h30, 8'h3f, 8'h41, 8'hff};
    logic [4:0] dv;
    pcar_cyc_type ek;
    pcar_tgt_type et;
    for (int i = 0; i < 10; i++)
    begin
      dv = i == 1 ? 5'h11 : 5'h05;
      ek = bl[i][3:0] == 4'h0 ? PCAR_CYC_CFG0 : PCAR_CYC_CFG1;
      et = i < 4 ? PCAR_TGT_GRAPHICS : i < 6 ? PCAR_TGT_SEC2 :
           i < 8 ? PCAR_TGT_SEC3 : PCAR_TGT_PRIMARY;
      dly = i[3:0];
      sel(bl[i], dv, 3'h3);
      io(i[0], PCAR_DATA_IO, PCAR_BE_DWORD, 32'h5a000000 | i);
      `CK({tgt, kind}, {et, ek})
      `CK(cbe, PCAR_BE_DWORD)
      if (ek == PCAR_CYC_CFG1)
        `CK(caddr[23:2], {bl[i], dv, 3'h3, 6'h2a})
      else if (i < 2)
        `CK(caddr[31:2], {i == 0 ? 16'h0020 : 16'h0, 5'h0, 9'h0ea})
      else
        `CK(caddr[15:2], {dv, 3'h3, 6'h2a})
      if (i[0])
        `CK({cwr, cwdata}, {1'b1, 32'h5a000000 | i})
    end
    $display("bridges done");
  endtask
  task automatic t_strap;
    do_reset(2'h1);
    int_en = 2'h3;
    sel(8'h0, 5'h3, 3'h0);
    io(1'b0, PCAR_DATA_IO, PCAR_BE_DWORD, 32'h0);
    `CK(tgt, PCAR_TGT_PRIMARY)
    $display("strap done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    do_reset(2'h3);
    t_regs();
    t_bus0();
    t_bridges();
    t_strap();
    end_of_test();
  end
  // About 45 accesses of under 30 cycles each; far beyond that is a hang
  initial
  begin
    #50000;
    fail_count++;
    end_of_test();
  end
endmodule
